/* tof_pkg.sv */
package tof_pkg;

    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CNT_W = 6;
    localparam int MAX_ENTRIES = 15;
    localparam int SLOT_W = 4;
    localparam logic [7:0] IN_LEN_RESET = 8'h04;
    localparam logic [7:0] OUT_LEN_SMALL = 8'h14;
    localparam logic [7:0] OUT_LEN_LARGE = 8'h3C;
    localparam logic [2:0] ENTRIES_SMALL = 3'h5;
    localparam logic [3:0] ENTRIES_LARGE = 4'hF;
    localparam int LAST_MARK_BIT = 6;
    localparam int PAT_OUT_LSB = 4;
    localparam logic [7:0] STS_FULL_BIT = 8'h01;
    localparam logic [7:0] STS_RUN_BIT = 8'h02;
    localparam logic [7:0] STS_LAST_BIT = 8'h80;
    localparam logic [7:0] NEXT_VALID_BIT = 8'hC0;

    typedef struct packed {
        logic [7:0] pattern;
        logic [7:0] running_number;
        logic [15:0] entry_time_us;
    } tof_entry_t;

    typedef struct packed {
        logic [7:0] last_accepted_number;
        logic [7:0] next_pending_number;
        logic [7:0] queue_status;
        logic [7:0] queued_entry_count;
    } tof_status_t;

endpackage

/* tof_timed_output_fifo.sv */
//Contract
// - Parameter set is fixed, writes ignored
// - Input image length always reads four bytes
// - Output image length equals build variant (reset loads OUT_LEN_SMALL in both variants)
// - Entry: pattern, number, 16-bit microsecond time
// - New entries appended in address order
// - At entry time drive pattern upper nibble, drop entry
// - Entries execute strictly in arrival order
// - Apply only when ticker equals entry time
// - Report last, next, status, queued count
`timescale 1ns/100ps
`default_nettype none
module tof_timed_output_fifo #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic image_write,
    input wire tof_pkg::tof_entry_t [tof_pkg::MAX_ENTRIES-1:0] output_image,
    input wire logic [15:0] ticker_us,
    input wire logic param_write,
    input wire logic [7:0] param_wdata,
    output logic [3:0] dout,
    output tof_pkg::tof_status_t input_image,
    output logic [7:0] input_image_length,
    output logic [7:0] output_image_length
);

    typedef enum logic [1:0] {
        TOF_IDLE = 2'b00,
        TOF_WAIT = 2'b01,
        TOF_FIRE = 2'b10
    } tof_state_t;

    wire tof_pkg::tof_entry_t mem [tof_pkg::FIFO_DEPTH];
    logic [tof_pkg::PTR_W-1:0] rd_ptr_reg;
    logic [tof_pkg::PTR_W-1:0] wr_ptr_reg;
    logic [tof_pkg::CNT_W-1:0] count_reg;
    logic [tof_pkg::CNT_W-1:0] count_next;
    tof_state_t state_reg;
    tof_state_t state_next;
    logic [15:0] tick_s1_reg;
    logic [15:0] tick_s2_reg;
    logic wr_s1_reg;
    logic wr_s2_reg;
    logic wr_s3_reg;
    logic [7:0] last_rn_reg;
    logic [7:0] exec_rn_reg;
    logic last_seen_reg;

    wire [3:0] slots = LARGE_VARIANT ? tof_pkg::ENTRIES_LARGE
                                     : 4'(tof_pkg::ENTRIES_SMALL);
    wire wr_pulse = wr_s2_reg & ~wr_s3_reg;
    wire [7:0] mark_mask = 8'h01 << tof_pkg::LAST_MARK_BIT;
    wire tof_pkg::tof_entry_t head = mem[rd_ptr_reg];
    wire time_hit = tick_s2_reg == head.entry_time_us;
    wire fire = (state_reg == TOF_WAIT) && time_hit && (count_reg != '0);
    wire [tof_pkg::CNT_W-1:0] free_slots =
        6'(tof_pkg::FIFO_DEPTH) - count_reg;

    // Count valid slots of a write; stop after the entry marked last
    wire [4:0] n_valid;
    wire [7:0] last_num;
    wire [tof_pkg::MAX_ENTRIES:0] open_chain;
    wire [4:0] cnt_chain [tof_pkg::MAX_ENTRIES+1];
    wire [7:0] num_chain [tof_pkg::MAX_ENTRIES+1];
    assign open_chain[0] = 1'b1;
    assign cnt_chain[0] = 5'h00;
    assign num_chain[0] = last_rn_reg;

    genvar s;
    generate
        for (s = 0; s < tof_pkg::MAX_ENTRIES; s++)
        begin : g_slot
            wire [7:0] slot_num = output_image[s].running_number;
            wire used = open_chain[s] && (4'(s) < slots);
            wire marked = slot_num[tof_pkg::LAST_MARK_BIT];
            wire ends = used && marked;
            assign open_chain[s+1] = open_chain[s] && !ends;
            assign cnt_chain[s+1] = cnt_chain[s] + (used ? 5'h01 : 5'h00);
            assign num_chain[s+1] = used ? slot_num : num_chain[s];
        end
    endgenerate
    assign n_valid = cnt_chain[tof_pkg::MAX_ENTRIES];
    assign last_num = num_chain[tof_pkg::MAX_ENTRIES];

    wire accept = wr_pulse && (6'(n_valid) <= free_slots);

    // Occupancy: a write and a fire may fall in the same clock
    always_comb
    begin
        count_next = count_reg;
        if (accept)
        begin
            count_next = count_next + 6'(n_valid);
        end
        if (fire)
        begin
            count_next = count_next - 6'h01;
        end
    end

    // Wait for the head time, then stay in FIRE until the next head's time no longer matches the ticker or the queue is empty
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TOF_IDLE:
            begin
                if (count_reg != '0)
                begin
                    state_next = TOF_WAIT;
                end
            end
            TOF_WAIT:
            begin
                if (fire)
                begin
                    state_next = TOF_FIRE;
                end
            end
            TOF_FIRE:
            begin
                // Hold FIRE while the ticker still matches so a head with equal time waits a wrap
                if (!time_hit || count_reg == '0)
                begin
                    state_next = (count_reg != '0) ? TOF_WAIT : TOF_IDLE;
                end
            end
            default:
            begin
                state_next = TOF_IDLE;
            end
        endcase
    end

    // Ticker comes from the head module: two flops before any logic
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_s1_reg <= 16'h0000;
            tick_s2_reg <= 16'h0000;
        end
        else
        begin
            tick_s1_reg <= ticker_us;
            tick_s2_reg <= tick_s1_reg;
        end
    end

    // Write strobe: two sync flops, a third one finds the rising edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_s1_reg <= 1'b0;
            wr_s2_reg <= 1'b0;
            wr_s3_reg <= 1'b0;
        end
        else
        begin
            wr_s1_reg <= image_write;
            wr_s2_reg <= wr_s1_reg;
            wr_s3_reg <= wr_s2_reg;
        end
    end

    // One register per FIFO cell; a write lands behind waiting entries
    genvar g;
    generate
        for (g = 0; g < tof_pkg::FIFO_DEPTH; g++)
        begin : g_cell
            wire [tof_pkg::PTR_W-1:0] ofs = 5'(g) - wr_ptr_reg;
            wire load_cell = accept && (ofs < n_valid);
            tof_pkg::tof_entry_t cell_reg;
            always_ff @(posedge sys_clk)
            begin
                if (load_cell)
                begin
                    cell_reg <= output_image[ofs[3:0]];
                end
            end
            assign mem[g] = cell_reg;
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (accept)
            begin
                wr_ptr_reg <= wr_ptr_reg + n_valid;
            end
            if (fire)
            begin
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            state_reg <= TOF_IDLE;
        end
        else
        begin
            count_reg <= count_next;
            state_reg <= state_next;
        end
    end

    // Applied pattern and the number of the entry behind it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dout <= 4'h0;
            exec_rn_reg <= 8'h00;
        end
        else if (fire)
        begin
            dout <= head.pattern[7:tof_pkg::PAT_OUT_LSB];
            exec_rn_reg <= head.running_number;
        end
    end

    // Last accepted number, reported with the last mark set
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_rn_reg <= 8'h00;
            last_seen_reg <= 1'b0;
        end
        else if (accept)
        begin
            last_rn_reg <= last_num | mark_mask;
            last_seen_reg <= last_num[tof_pkg::LAST_MARK_BIT];
        end
    end

    // Status bytes returned to the controlling station
    wire queue_busy = count_reg != '0;
    wire queue_full = free_slots == '0;
    wire [7:0] sts_last = last_seen_reg ? tof_pkg::STS_LAST_BIT : 8'h00;
    wire [7:0] sts_run = queue_busy ? tof_pkg::STS_RUN_BIT : 8'h00;
    wire [7:0] sts_full = queue_full ? tof_pkg::STS_FULL_BIT : 8'h00;
    wire [7:0] sts = sts_last | sts_run | sts_full;
    // When empty, report the number after the last executed one
    wire [7:0] after_exec = exec_rn_reg + 8'h01;
    wire [7:0] next_raw = queue_busy ? head.running_number : after_exec;
    wire [7:0] next_num = next_raw | tof_pkg::NEXT_VALID_BIT;

    // Status bytes refresh every clock
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            input_image <= '0;
        end
        else
        begin
            input_image.last_accepted_number <= last_rn_reg;
            input_image.next_pending_number <= next_num;
            input_image.queue_status <= sts;
            input_image.queued_entry_count <= 8'(count_reg);
        end
    end

    // Lengths are fixed; the parameter write inputs are left unread
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            input_image_length <= tof_pkg::IN_LEN_RESET;
            output_image_length <= tof_pkg::OUT_LEN_SMALL;
        end
        else
        begin
            input_image_length <= tof_pkg::IN_LEN_RESET;
            output_image_length <= LARGE_VARIANT ? tof_pkg::OUT_LEN_LARGE
                                   : tof_pkg::OUT_LEN_SMALL;
        end
    end

endmodule
`default_nettype wire

/* tof_timed_output_fifo_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tof_chk #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic image_write,
    input wire logic param_write,
    input wire logic [3:0] dout,
    input wire tof_pkg::tof_status_t input_image,
    input wire logic [7:0] input_image_length,
    input wire logic [7:0] output_image_length
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic [7:0] cnt = input_image.queued_entry_count;
    wire logic [7:0] nxt = input_image.next_pending_number;
    wire logic [7:0] sts = input_image.queue_status;
    property p_in_len;
        input_image_length == tof_pkg::IN_LEN_RESET;
    endproperty
    a_in_len: assert property (p_in_len) else $error("in len");
    property p_out_len;
        $past(rst_n) |-> output_image_length ==
            (LARGE_VARIANT ? tof_pkg::OUT_LEN_LARGE : tof_pkg::OUT_LEN_SMALL);
    endproperty
    a_out_len: assert property (p_out_len) else $error("out len");
    property p_param;
        param_write && $past(rst_n) |=> $stable(output_image_length);
    endproperty
    a_param: assert property (p_param) else $error("param write");
    property p_dout;
        $changed(dout) |-> $past(cnt) != 8'h00;
    endproperty
    a_dout: assert property (p_dout) else $error("dout w/o entry");
    property p_cnt;
        $rose(image_write) && cnt == 8'h00 |-> ##[4:7] cnt != 8'h00;
    endproperty
    a_cnt: assert property (p_cnt) else $error("entries lost");
    property p_run;
        cnt != 8'h00 && $past(cnt) != 8'h00 |-> sts[1];
    endproperty
    a_run: assert property (p_run) else $error("run flag");
    property p_next;
        cnt != 8'h00 |-> nxt[7:6] == 2'b11;
    endproperty
    a_next: assert property (p_next) else $error("next number");
    property p_max;
        cnt <= 8'h20;
    endproperty
    a_max: assert property (p_max) else $error("count over depth");
endmodule
bind tof_timed_output_fifo tof_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_tof_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .image_write(image_write),
    .param_write(param_write), .dout(dout), .input_image(input_image),
    .input_image_length(input_image_length),
    .output_image_length(output_image_length));
`default_nettype wire

/* tof_head_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tof_head_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [15:0] load_val,
    output logic [15:0] ticker_us
);
    // One step per clock keeps runs short; load jumps ahead
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ticker_us <= 16'h0000;
        else if (load)
            ticker_us <= load_val;
        else
            ticker_us <= ticker_us + 16'h0001;
    end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic image_write = 1'b0;
    logic param_write = 1'b0;
    logic [7:0] param_wdata = 8'h00;
    logic load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [15:0] ticker_us;
    logic [3:0] dout;
    logic [7:0] input_image_length;
    logic [7:0] output_image_length;
    tof_pkg::tof_entry_t [tof_pkg::MAX_ENTRIES-1:0] output_image = '0;
    tof_pkg::tof_status_t input_image;
    tof_pkg::tof_entry_t q[8];
    logic [15:0] tm[8] = '{16'h1770, 16'h30DA, 16'h86D6, 16'hC176,
        16'hD501, 16'h0004, 16'h309B, 16'h4ED9};
    int n_mismatch = 0;
    int check_count = 0;
    always #2 sys_clk = ~sys_clk;
    tof_head_model u_tof_head_model (.sys_clk, .rst_n, .load, .load_val,
        .ticker_us);
    tof_timed_output_fifo u_tof_timed_output_fifo (.sys_clk, .rst_n,
        .image_write, .output_image, .ticker_us, .param_write, .param_wdata,
        .dout, .input_image, .input_image_length, .output_image_length);
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] exp_next(int i);
        if (i < 7)
            return q[i + 1].running_number | 8'hC0;
        return (q[7].running_number + 8'h01) | 8'hC0;
    endfunction
    function automatic logic [7:0] exp_fill(int i);
        return (i < 6) ? 8'(5 * i + 5) : 8'(30);
    endfunction
    task automatic send(tof_pkg::tof_entry_t [tof_pkg::MAX_ENTRIES-1:0] img);
        @(posedge sys_clk);
        output_image <= img;
        image_write <= 1'b1;
        repeat (4) @(posedge sys_clk);
        image_write <= 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic fire(tof_pkg::tof_entry_t e, logic [7:0] n);
        int k;
        @(posedge sys_clk);
        load <= 1'b1;
        load_val <= e.entry_time_us - 16'h000C;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (8) @(negedge sys_clk);
        cmp("early", n + 8'h01, input_image.queued_entry_count);
        for (k = 0; k < 40 && input_image.queued_entry_count !== n; k++)
            @(negedge sys_clk);
        if (k == 40)
        begin
            n_mismatch++;
            end_of_test;
        end
        @(negedge sys_clk);
        cmp("dout", {4'h0, e.pattern[7:4]}, {4'h0, dout});
    endtask
    initial
    begin
        int i;
        tof_pkg::tof_entry_t [tof_pkg::MAX_ENTRIES-1:0] img;
        void'($urandom(80));
        for (i = 0; i < 8; i++)
            q[i] = {4'($urandom()), 4'h0, 8'(i + 1), tm[i]};
        q[7].running_number[6] = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        param_write <= 1'b1;
        param_wdata <= 8'($urandom());
        @(posedge sys_clk);
        param_write <= 1'b0;
        @(negedge sys_clk);
        cmp("in_len", 8'h04, input_image_length);
        cmp("out_len", 8'h14, output_image_length);
        img = '0;
        for (i = 0; i < 5; i++)
            img[i] = q[i];
        send(img);
        cmp("count", 8'h05, input_image.queued_entry_count);
        cmp("last", 8'h45, input_image.last_accepted_number);
        cmp("next", 8'hC1, input_image.next_pending_number);
        cmp("status", 8'h02, input_image.queue_status);
        img = '0;
        for (i = 0; i < 3; i++)
            img[i] = q[i + 5];
        send(img);
        cmp("count", 8'h08, input_image.queued_entry_count);
        cmp("last", 8'h48, input_image.last_accepted_number);
        cmp("status", 8'h82, input_image.queue_status);
        for (i = 0; i < 8; i++)
        begin
            fire(q[i], 8'(7 - i));
            cmp("next", exp_next(i), input_image.next_pending_number);
        end
        for (i = 0; i < 15; i++)
            img[i] = {8'h30, 8'(i + 1), 16'h8000};
        for (i = 0; i < 7; i++)
        begin
            send(img);
            cmp("fill", exp_fill(i), input_image.queued_entry_count);
        end
        img[1].running_number = 8'h42;
        send(img);
        cmp("fill", 8'h20, input_image.queued_entry_count);
        cmp("status", 8'h83, input_image.queue_status);
        cmp("last", 8'h42, input_image.last_accepted_number);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(negedge sys_clk);
        cmp("rst_cnt", 8'h00, input_image.queued_entry_count);
        cmp("rst_dout", 8'h00, {4'h0, dout});
        end_of_test;
    end
endmodule
`default_nettype wire
